//--- logic/clock_config_pkg.sv
// Constants shared by the oscillator, PLL and clock configuration block
`default_nettype none
package clock_config_pkg;

  // Register word indices on the plain register port
  localparam logic [7:0] ADDR_CLOCK_DIVISOR = 8'h00;
  localparam logic [7:0] ADDR_PLL_FEEDBACK = 8'h01;
  localparam logic [7:0] ADDR_FAST_RC_TUNE = 8'h02;
  localparam logic [7:0] ADDR_OSC_CONTROL = 8'h03;

  // Clock divisor register fields
  localparam int RECOVER_ON_IRQ_BIT = 15;
  localparam int DOZE_RATIO_LSB = 12;
  localparam int DOZE_ENABLE_BIT = 11;
  localparam int FAST_RC_POSTSCALE_LSB = 8;
  localparam int PLL_POSTSCALE_LSB = 6;
  localparam int PLL_PRESCALE_LSB = 0;
  localparam logic [15:0] CLOCK_DIVISOR_WMASK = 16'hffdf;
  localparam logic [15:0] CLOCK_DIVISOR_RST = 16'h3040;

  // Feedback, tuning and control fields
  localparam int FEEDBACK_W = 9;
  localparam logic [8:0] PLL_FEEDBACK_RST = 9'h01e;
  localparam int TUNE_W = 6;
  localparam logic [5:0] FAST_RC_TUNE_RST = 6'h00;
  localparam int FAILSAFE_EN_BIT = 0;
  localparam int AUX_MODE_LSB = 1;
  localparam int CLOCK_FAIL_BIT = 3;
  localparam int PLL_LOCK_BIT = 4;
  localparam int CURRENT_SOURCE_LSB = 8;
  localparam int PRIMARY_MODE_LSB = 12;
  localparam logic FAILSAFE_EN_RST = 1'b0;
  localparam logic [1:0] AUX_MODE_RST = 2'h0;

  // Initial source selection codes
  localparam logic [2:0] SRC_FAST_RC = 3'h0;
  localparam logic [2:0] SRC_FAST_RC_PLL = 3'h1;
  localparam logic [2:0] SRC_PRIMARY = 3'h2;
  localparam logic [2:0] SRC_PRIMARY_PLL = 3'h3;
  localparam logic [2:0] SRC_SECONDARY = 3'h4;
  localparam logic [2:0] SRC_LOW_POWER_RC = 3'h5;
  localparam logic [2:0] SRC_FAST_RC_DIV16 = 3'h6;
  localparam logic [2:0] SRC_FAST_RC_DIVN = 3'h7;

  // Primary oscillator modes
  localparam logic [1:0] EXTERNAL_CLOCK_MODE = 2'h0;
  localparam logic [1:0] CRYSTAL_MODE = 2'h1;
  localparam logic [1:0] HIGH_SPEED_CRYSTAL_MODE = 2'h2;
  localparam logic [1:0] PRIMARY_OFF_MODE = 2'h3;

  // Divider and monitor constants
  localparam logic [3:0] FAST_RC_DIV16_LOG2 = 4'h4;
  localparam logic [5:0] PRESCALE_OFFSET = 6'h02;
  localparam logic [9:0] FEEDBACK_OFFSET = 10'h002;
  localparam logic [1:0] FAIL_REF_TICKS = 2'h2;
  localparam logic [15:0] LOCK_JITTER = 16'h0001;

  // Oscillator pin indices
  localparam int PIN_FAST_RC = 0;
  localparam int PIN_PRIMARY = 1;
  localparam int PIN_SECONDARY = 2;
  localparam int PIN_LOW_POWER_RC = 3;
  localparam int PIN_AUX = 4;
  localparam int PIN_COUNT = 5;

endpackage
`default_nettype wire

//--- logic/oscillator_pll_clock_config.sv
// Oscillator selection, fast RC postscaler, digital PLL and clock dividers
//
// The plain strobed port and the register addresses were left to the implementer.
`default_nettype none

module oscillator_pll_clock_config
(
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Nonvolatile configuration
  input wire logic [2:0] initial_source_sel_in,
  input wire logic [1:0] primary_osc_mode_sel_in,
  // Oscillator pins
  input wire logic fast_rc_osc_in,
  input wire logic primary_osc_in,
  input wire logic secondary_low_power_osc_in,
  input wire logic low_power_rc_osc_in,
  input wire logic auxiliary_osc_in,
  // Wake event from interrupt controller
  input wire logic interrupt_in,
  // Register port
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [15:0] rd_data_out,
  // Generated clock ticks
  output logic sys_osc_tick_out,
  output logic instr_clk_tick_out,
  output logic peripheral_clock_tick_out,
  output logic cpu_clk_tick_out,
  output logic watchdog_timer_ref_tick_out,
  output logic auxiliary_osc_tick_out,
  // Status and analog controls
  output logic [2:0] current_source_out,
  output logic pll_lock_out,
  output logic clock_fail_out,
  output logic [5:0] fast_rc_tune_out,
  output logic [1:0] auxiliary_osc_mode_out
);

  localparam int NP = clock_config_pkg::PIN_COUNT;

  typedef enum logic [1:0]
  {
    CFG_WAIT = 2'b01,
    CFG_RUN = 2'b10
  } phase_e;

  typedef struct packed
  {
    logic [NP-1:0] sync1;
    logic [NP-1:0] sync2;
    logic [NP-1:0] sync3;
    logic [NP-1:0] filt;
    phase_e phase;
    logic [2:0] cur_src;
    logic [1:0] posc_mode;
    logic [15:0] clock_divisor_reg;
    logic [8:0] pll_feedback_reg;
    logic [5:0] tune;
    logic failsafe_clock_monitor_en;
    logic [1:0] aux_mode;
    logic clk_fail;
    logic [2:0] act_frc;
    logic [4:0] act_pre;
    logic [8:0] act_fbd;
    logic [1:0] act_post;
    logic [2:0] act_doze;
    logic act_dozen;
    logic [7:0] frc_cnt;
    logic [7:0] pre_cnt;
    logic [15:0] per_cnt;
    logic [15:0] period;
    logic [16:0] acc;
    logic lock;
    logic [7:0] post_cnt;
    logic half;
    logic [7:0] doze_cnt;
    logic [1:0] fail_cnt;
    logic fosc_tick;
    logic instr_tick;
    logic cpu_tick;
    logic low_power_rc_osc_tick;
    logic aux_tick;
    logic [15:0] rdata;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // Last count of a divide by two to the power e
  function automatic logic [7:0] pow2_last(input logic [3:0] e);
    logic [8:0] t;
    t = 9'h001 << e;
    return 8'(t - 9'h001);
  endfunction

  // Free-running divider step
  function automatic logic [7:0] div_step(input logic [7:0] cnt,
                                          input logic [7:0] last);
    return (cnt >= last) ? 8'h00 : 8'(cnt + 8'h01);
  endfunction

  always_comb
  begin
    logic [NP-1:0] rise;
    logic raw_tick;
    logic stage1;
    logic stage2;
    logic vco_in;
    logic vco_tick;
    logic use_pll;
    logic changed;
    logic [7:0] frc_last;
    logic [7:0] pre_last;
    logic [7:0] post_last;
    logic [9:0] mult;
    logic [16:0] sum;
    logic [15:0] new_period;
    logic [15:0] diff;
    rise = '0;
    raw_tick = 1'b0;
    stage1 = 1'b0;
    stage2 = 1'b0;
    vco_in = 1'b0;
    vco_tick = 1'b0;
    changed = 1'b0;
    use_pll = 1'b0;
    frc_last = 8'h00;
    pre_last = 8'h00;
    post_last = 8'h00;
    mult = 10'h000;
    sum = '0;
    new_period = '0;
    diff = '0;
    state_next = state_reg;
    state_next.fosc_tick = 1'b0;
    state_next.instr_tick = 1'b0;
    state_next.cpu_tick = 1'b0;
    state_next.rdata = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: a level counts once stages two and three agree
    state_next.sync1 = {auxiliary_osc_in, low_power_rc_osc_in,
                        secondary_low_power_osc_in, primary_osc_in,
                        fast_rc_osc_in};
    state_next.sync2 = state_reg.sync1;
    state_next.sync3 = state_reg.sync2;
    for (int i = 0; i < NP; i++)
    begin
      if (state_reg.sync2[i] == state_reg.sync3[i])
      begin
        state_next.filt[i] = state_reg.sync3[i];
      end
      rise[i] = state_reg.sync2[i] & state_reg.sync3[i] &
                ~state_reg.filt[i];
    end
    state_next.low_power_rc_osc_tick = rise[clock_config_pkg::PIN_LOW_POWER_RC];
    state_next.aux_tick = rise[clock_config_pkg::PIN_AUX];

    ////////////////////////////////////////////////////////////////////////
    // Power-on source capture
    case (state_reg.phase)
      CFG_WAIT:
      begin
        state_next.cur_src = initial_source_sel_in;
        state_next.posc_mode = primary_osc_mode_sel_in;
        state_next.phase = CFG_RUN;
      end
      CFG_RUN:
      begin
        state_next.phase = CFG_RUN;
      end
      default:
      begin
        state_next.phase = CFG_WAIT;
      end
    endcase

    ////////////////////////////////////////////////////////////////////////
    // Source selection and fast RC postscaler
    case (state_reg.cur_src)
      clock_config_pkg::SRC_PRIMARY,
      clock_config_pkg::SRC_PRIMARY_PLL:
      begin
        raw_tick = rise[clock_config_pkg::PIN_PRIMARY] &&
                   state_reg.posc_mode != clock_config_pkg::PRIMARY_OFF_MODE;
      end
      clock_config_pkg::SRC_SECONDARY:
      begin
        raw_tick = rise[clock_config_pkg::PIN_SECONDARY];
      end
      clock_config_pkg::SRC_LOW_POWER_RC:
      begin
        raw_tick = rise[clock_config_pkg::PIN_LOW_POWER_RC];
      end
      default:
      begin
        raw_tick = rise[clock_config_pkg::PIN_FAST_RC];
      end
    endcase
    if (state_reg.phase != CFG_RUN)
    begin
      raw_tick = 1'b0;
    end
    use_pll = state_reg.cur_src == clock_config_pkg::SRC_FAST_RC_PLL ||
              state_reg.cur_src == clock_config_pkg::SRC_PRIMARY_PLL;
    if (state_reg.cur_src == clock_config_pkg::SRC_FAST_RC_DIVN)
    begin
      frc_last = pow2_last({1'b0, state_reg.act_frc} + 4'h1);
    end
    else if (state_reg.cur_src == clock_config_pkg::SRC_FAST_RC_DIV16)
    begin
      frc_last = pow2_last(clock_config_pkg::FAST_RC_DIV16_LOG2);
    end
    else
    begin
      frc_last = 8'h00;
    end
    if (raw_tick)
    begin
      stage1 = state_reg.frc_cnt >= frc_last;
      state_next.frc_cnt = div_step(state_reg.frc_cnt, frc_last);
    end

    ////////////////////////////////////////////////////////////////////////
    // Digital PLL: prescaler, period-tracking VCO, postscaler
    pre_last = 8'({1'b0, state_reg.act_pre} + clock_config_pkg::PRESCALE_OFFSET
                  - 6'h01);
    mult = 10'(state_reg.act_fbd) + clock_config_pkg::FEEDBACK_OFFSET;
    post_last = pow2_last(state_reg.act_post[1] ? 4'h3 :
                          (state_reg.act_post[0] ? 4'h2 : 4'h1));
    if (use_pll && stage1)
    begin
      vco_in = state_reg.pre_cnt >= pre_last;
      state_next.pre_cnt = div_step(state_reg.pre_cnt, pre_last);
    end
    state_next.per_cnt = (state_reg.per_cnt == 16'hffff) ? state_reg.per_cnt :
                         16'(state_reg.per_cnt + 16'h0001);
    if (vco_in)
    begin
      new_period = 16'(state_reg.per_cnt + 16'h0001);
      diff = (new_period > state_reg.period) ?
             16'(new_period - state_reg.period) :
             16'(state_reg.period - new_period);
      state_next.period = new_period;
      state_next.per_cnt = 16'h0000;
      state_next.lock = diff <= clock_config_pkg::LOCK_JITTER &&
                        {6'h00, mult} < new_period;
    end
    if (!use_pll)
    begin
      state_next.lock = 1'b0;
    end
    if (use_pll && state_reg.period != 16'h0000)
    begin
      sum = 17'(state_reg.acc + {7'h00, mult});
      if (sum >= {1'b0, state_reg.period})
      begin
        vco_tick = 1'b1;
        state_next.acc = 17'(sum - {1'b0, state_reg.period});
      end
      else
      begin
        state_next.acc = sum;
      end
    end
    if (vco_tick)
    begin
      stage2 = state_reg.post_cnt >= post_last;
      state_next.post_cnt = div_step(state_reg.post_cnt, post_last);
    end
    if (!use_pll)
    begin
      stage2 = stage1;
    end

    ////////////////////////////////////////////////////////////////////////
    // System clock halving, doze and boundary update of settings
    state_next.fosc_tick = stage2;
    if (stage2)
    begin
      state_next.half = ~state_reg.half;
      if (state_reg.half)
      begin
        state_next.instr_tick = 1'b1;
        if (!state_reg.act_dozen)
        begin
          state_next.cpu_tick = 1'b1;
        end
        else
        begin
          state_next.cpu_tick = state_reg.doze_cnt >=
                                pow2_last({1'b0, state_reg.act_doze});
          state_next.doze_cnt = div_step(state_reg.doze_cnt,
                                  pow2_last({1'b0, state_reg.act_doze}));
        end
        // New divisors only at an instruction clock boundary
        state_next.act_frc = state_reg.clock_divisor_reg[10:8];
        state_next.act_pre = state_reg.clock_divisor_reg[4:0];
        state_next.act_post = state_reg.clock_divisor_reg[7:6];
        state_next.act_fbd = state_reg.pll_feedback_reg;
        state_next.act_doze = state_reg.clock_divisor_reg[14:12];
        state_next.act_dozen = state_reg.clock_divisor_reg[
                                 clock_config_pkg::DOZE_ENABLE_BIT];
        changed = state_next.act_frc != state_reg.act_frc ||
                  state_next.act_pre != state_reg.act_pre ||
                  state_next.act_post != state_reg.act_post ||
                  state_next.act_fbd != state_reg.act_fbd ||
                  state_next.act_doze != state_reg.act_doze;
      end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fail-safe clock monitor on the low-power RC reference
    if (state_reg.failsafe_clock_monitor_en && state_reg.phase == CFG_RUN &&
        state_reg.cur_src != clock_config_pkg::SRC_LOW_POWER_RC)
    begin
      if (raw_tick)
      begin
        state_next.fail_cnt = 2'h0;
      end
      else if (rise[clock_config_pkg::PIN_LOW_POWER_RC])
      begin
        state_next.fail_cnt = 2'(state_reg.fail_cnt + 2'h1);
      end
    end
    else
    begin
      state_next.fail_cnt = 2'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register port
    if (wr_en_in)
    begin
      case (addr_in)
        clock_config_pkg::ADDR_CLOCK_DIVISOR:
        begin
          state_next.clock_divisor_reg = wr_data_in &
                                         clock_config_pkg::CLOCK_DIVISOR_WMASK;
        end
        clock_config_pkg::ADDR_PLL_FEEDBACK:
        begin
          state_next.pll_feedback_reg = wr_data_in[8:0];
        end
        clock_config_pkg::ADDR_FAST_RC_TUNE:
        begin
          state_next.tune = wr_data_in[5:0];
        end
        clock_config_pkg::ADDR_OSC_CONTROL:
        begin
          state_next.failsafe_clock_monitor_en = wr_data_in[clock_config_pkg::FAILSAFE_EN_BIT];
          state_next.aux_mode = wr_data_in[clock_config_pkg::AUX_MODE_LSB +:
                                           2];
          if (wr_data_in[clock_config_pkg::CLOCK_FAIL_BIT])
          begin
            state_next.clk_fail = 1'b0;
          end
        end
        default:
        begin
        end
      endcase
    end
    if (rd_en_in)
    begin
      case (addr_in)
        clock_config_pkg::ADDR_CLOCK_DIVISOR:
        begin
          state_next.rdata = state_reg.clock_divisor_reg;
        end
        clock_config_pkg::ADDR_PLL_FEEDBACK:
        begin
          state_next.rdata = {7'h00, state_reg.pll_feedback_reg};
        end
        clock_config_pkg::ADDR_FAST_RC_TUNE:
        begin
          state_next.rdata = {10'h000, state_reg.tune};
        end
        clock_config_pkg::ADDR_OSC_CONTROL:
        begin
          state_next.rdata = {2'h0, state_reg.posc_mode, 1'b0,
                              state_reg.cur_src, 3'h0, state_reg.lock,
                              state_reg.clk_fail, state_reg.aux_mode,
                              state_reg.failsafe_clock_monitor_en};
        end
        default:
        begin
          state_next.rdata = 16'h0000;
        end
      endcase
    end
    if (interrupt_in &&
        state_reg.clock_divisor_reg[clock_config_pkg::RECOVER_ON_IRQ_BIT])
    begin
      state_next.clock_divisor_reg[clock_config_pkg::DOZE_ENABLE_BIT] = 1'b0;
    end

    // Failure wins over a clear in the same cycle
    if (state_reg.fail_cnt >= clock_config_pkg::FAIL_REF_TICKS)
    begin
      state_next.clk_fail = 1'b1;
      state_next.cur_src = clock_config_pkg::SRC_FAST_RC;
      state_next.fail_cnt = 2'h0;
      changed = 1'b1;
    end
    if (changed)
    begin
      state_next.frc_cnt = 8'h00;
      state_next.pre_cnt = 8'h00;
      state_next.post_cnt = 8'h00;
      state_next.doze_cnt = 8'h00;
      state_next.acc = 17'h00000;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= '0;
      state_reg.phase <= CFG_WAIT;
      state_reg.cur_src <= clock_config_pkg::SRC_FAST_RC;
      state_reg.clock_divisor_reg <= clock_config_pkg::CLOCK_DIVISOR_RST;
      state_reg.pll_feedback_reg <= clock_config_pkg::PLL_FEEDBACK_RST;
      state_reg.tune <= clock_config_pkg::FAST_RC_TUNE_RST;
      state_reg.failsafe_clock_monitor_en <= clock_config_pkg::FAILSAFE_EN_RST;
      state_reg.aux_mode <= clock_config_pkg::AUX_MODE_RST;
      state_reg.act_frc <= clock_config_pkg::CLOCK_DIVISOR_RST[10:8];
      state_reg.act_pre <= clock_config_pkg::CLOCK_DIVISOR_RST[4:0];
      state_reg.act_post <= clock_config_pkg::CLOCK_DIVISOR_RST[7:6];
      state_reg.act_fbd <= clock_config_pkg::PLL_FEEDBACK_RST;
      state_reg.act_doze <= clock_config_pkg::CLOCK_DIVISOR_RST[14:12];
      state_reg.act_dozen <= clock_config_pkg::CLOCK_DIVISOR_RST[11];
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign rd_data_out = state_reg.rdata;
  assign sys_osc_tick_out = state_reg.fosc_tick;
  assign instr_clk_tick_out = state_reg.instr_tick;
  assign peripheral_clock_tick_out = state_reg.instr_tick;
  assign cpu_clk_tick_out = state_reg.cpu_tick;
  assign watchdog_timer_ref_tick_out = state_reg.low_power_rc_osc_tick;
  assign auxiliary_osc_tick_out = state_reg.aux_tick;
  assign current_source_out = state_reg.cur_src;
  assign pll_lock_out = state_reg.lock;
  assign clock_fail_out = state_reg.clk_fail;
  assign fast_rc_tune_out = state_reg.tune;
  assign auxiliary_osc_mode_out = state_reg.aux_mode;

endmodule
`default_nettype wire

//--- verification/clock_config_monitor.sv
// Port checker for the oscillator and PLL clock block
`default_nettype none
module clock_config_monitor
(
  // Clock, reset and inputs
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic rd_en_in,
  input wire logic low_power_rc_osc_in,
  input wire logic auxiliary_osc_in,
  // Outputs watched
  input wire logic [15:0] rd_data_out,
  input wire logic sys_osc_tick_out,
  input wire logic instr_clk_tick_out,
  input wire logic peripheral_clock_tick_out,
  input wire logic cpu_clk_tick_out,
  input wire logic watchdog_timer_ref_tick_out,
  input wire logic auxiliary_osc_tick_out,
  input wire logic [2:0] current_source_out,
  input wire logic clock_fail_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // System ticks seen since the last instruction tick
  logic [1:0] sys_cnt_reg;
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      sys_cnt_reg <= 2'h0;
    else if (instr_clk_tick_out)
      sys_cnt_reg <= 2'h0;
    else if (sys_osc_tick_out && sys_cnt_reg != 2'h3)
      sys_cnt_reg <= sys_cnt_reg + 2'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  rd_idle_a: assert property (!$past(rd_en_in) |-> rd_data_out == 16'h0000)
    else $error("read data outside its slot");
  instr_on_sys_a: assert property (
    instr_clk_tick_out |-> sys_osc_tick_out)
    else $error("instruction tick without system tick");
  instr_half_a: assert property (
    instr_clk_tick_out |-> sys_cnt_reg == 2'h1)
    else $error("instruction tick not every second system tick");
  periph_equal_a: assert property (
    peripheral_clock_tick_out == instr_clk_tick_out)
    else $error("peripheral tick differs from instruction tick");
  cpu_in_instr_a: assert property (
    cpu_clk_tick_out |-> instr_clk_tick_out)
    else $error("cpu tick outside instruction tick");
  sys_no_runt_a: assert property (
    sys_osc_tick_out |=> !sys_osc_tick_out)
    else $error("system ticks back to back");
  fail_to_rc_a: assert property (
    $rose(clock_fail_out) |-> current_source_out ==
    clock_config_pkg::SRC_FAST_RC)
    else $error("clock failure did not fall back to fast RC");
  wdt_ref_tick_a: assert property (
    $rose(low_power_rc_osc_in) |-> ##[1:8] watchdog_timer_ref_tick_out)
    else $error("watchdog reference tick missing");
  aux_tick_seen_a: assert property (
    $rose(auxiliary_osc_in) |-> ##[1:8] auxiliary_osc_tick_out)
    else $error("auxiliary tick missing");
  cover property (instr_clk_tick_out && cpu_clk_tick_out);
  cover property ($rose(clock_fail_out));
  cover property (instr_clk_tick_out && !cpu_clk_tick_out);
endmodule
bind oscillator_pll_clock_config clock_config_monitor u_clock_config_monitor
(
  .core_clk_in(core_clk_in),
  .rst_n_in(rst_n_in),
  .rd_en_in(rd_en_in),
  .low_power_rc_osc_in(low_power_rc_osc_in),
  .auxiliary_osc_in(auxiliary_osc_in),
  .rd_data_out(rd_data_out),
  .sys_osc_tick_out(sys_osc_tick_out),
  .instr_clk_tick_out(instr_clk_tick_out),
  .peripheral_clock_tick_out(peripheral_clock_tick_out),
  .cpu_clk_tick_out(cpu_clk_tick_out),
  .watchdog_timer_ref_tick_out(watchdog_timer_ref_tick_out),
  .auxiliary_osc_tick_out(auxiliary_osc_tick_out),
  .current_source_out(current_source_out),
  .clock_fail_out(clock_fail_out)
);
`default_nettype wire

//--- verification/osc_source_model.sv
// Oscillator pins seen by the clock block, all free-running except the primary, which primary_stop_in can stop
`default_nettype none
module osc_source_model
(
  // Control
  input wire logic primary_stop_in,
  // Oscillator pins
  output logic fast_rc_out,
  output logic primary_out,
  output logic secondary_out,
  output logic low_power_rc_osc_out,
  output logic aux_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    fast_rc_out = 1'b0;
    primary_out = 1'b0;
    secondary_out = 1'b0;
    low_power_rc_osc_out = 1'b0;
    aux_out = 1'b0;
  end
  always #800 fast_rc_out = ~fast_rc_out;
  // Failed crystal stops dead
  always #1280 primary_out = primary_stop_in ? 1'b0 : ~primary_out;
  always #1600 secondary_out = ~secondary_out;
  always #4000 low_power_rc_osc_out = ~low_power_rc_osc_out;
  // Applied external clock on the auxiliary pin
  always #240 aux_out = ~aux_out;
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the oscillator and PLL clock block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int W = 2000;
  logic core_clk_in, rst_n_in, irq, wr_en, rd_en, pstop;
  logic [2:0] src, cur;
  logic [1:0] pm, amode;
  logic [7:0] addr;
  logic [15:0] wdata, rdata;
  logic fast, prim, sec, low_power_rc_osc, aux, lock, fail;
  logic sys_t, instr_t, per_t, cpu_t, wdt_t, aux_t;
  logic [5:0] tune;
  int errors, n_tests, seed, ic, cc, pc, wc, ac;
  int tsrc[13] = '{0, 1, 2, 2, 2, 3, 3, 3, 4, 5, 6, 7, 2};
  int tpm[13] = '{-1, -1, 0, 1, 2, 0, 1, 2, -1, -1, -1, -1, 3};
  int tper[13] = '{80, 20, 128, 128, 128, 32, 32, 32, 160, 400, 1280, 160, 0};
  int ppre[6] = '{0, 1, 31, 0, 0, 0};
  int pmul[6] = '{30, 30, 511, 0, 0, 0};
  int ppost[6] = '{0, 1, 3, 2, 0, 0};
  oscillator_pll_clock_config u_oscillator_pll_clock_config
  (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
    .initial_source_sel_in(src), .primary_osc_mode_sel_in(pm),
    .fast_rc_osc_in(fast), .primary_osc_in(prim),
    .secondary_low_power_osc_in(sec), .low_power_rc_osc_in(low_power_rc_osc),
    .auxiliary_osc_in(aux), .interrupt_in(irq), .addr_in(addr),
    .wr_data_in(wdata), .wr_en_in(wr_en), .rd_en_in(rd_en),
    .rd_data_out(rdata), .sys_osc_tick_out(sys_t),
    .instr_clk_tick_out(instr_t), .peripheral_clock_tick_out(per_t),
    .cpu_clk_tick_out(cpu_t), .watchdog_timer_ref_tick_out(wdt_t),
    .auxiliary_osc_tick_out(aux_t), .current_source_out(cur),
    .pll_lock_out(lock), .clock_fail_out(fail),
    .fast_rc_tune_out(tune), .auxiliary_osc_mode_out(amode)
  );
  osc_source_model u_osc_source_model
  (
    .primary_stop_in(pstop), .fast_rc_out(fast), .primary_out(prim),
    .secondary_out(sec), .low_power_rc_osc_out(low_power_rc_osc), .aux_out(aux)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic near(input string nm, input int seen, exp);
    check(nm, 16'((seen >= exp - 1 && seen <= exp + 1) ? exp : seen),
          16'(exp));
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge core_clk_in);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk_in);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk_in);
    rd_en <= 1'b0;
    @(negedge core_clk_in);
    d = rdata;
  endtask
  task automatic boot(input logic [2:0] s, input logic [1:0] p);
    @(posedge core_clk_in);
    rst_n_in <= 1'b0;
    src <= s;
    pm <= p;
    pstop <= 1'b0;
    repeat (20) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    repeat (600) @(posedge core_clk_in);
  endtask
  task automatic meas(input int settle);
    repeat (settle) @(posedge core_clk_in);
    {ic, cc, pc, wc, ac} = '0;
    repeat (W)
    begin
      @(negedge core_clk_in);
      ic += int'(instr_t);
      cc += int'(cpu_t);
      pc += int'(per_t);
      wc += int'(wdt_t);
      ac += int'(aux_t);
    end
  endtask
  function automatic int pll_exp(int pre, m, post);
    int n2;
    n2 = (post == 0) ? 2 : (post == 1) ? 4 : 8;
    return W * (m + 2) / (128 * n2 * (pre + 2));
  endfunction
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end
  initial
  begin
    #4000000;
    errors++;
    end_of_test();
  end
  initial
  begin
    int p, pre, m, post;
    logic [15:0] v, t;
    {rst_n_in, irq, wr_en, rd_en, pstop, src, pm} = '0;
    {addr, wdata, errors, n_tests} = '0;
    seed = 32'h6c90;
    for (int i = 0; i < 13; i++)
    begin
      p = (tpm[i] < 0) ? {$random(seed)} % 4 : tpm[i];
      boot(3'(tsrc[i]), 2'(p));
      meas(0);
      check("source", 16'(cur), 16'(tsrc[i]));
      near("instr_rate", ic, tper[i] ? W / tper[i] : 0);
      check("periph_rate", 16'(pc), 16'(ic));
      rd(clock_config_pkg::ADDR_OSC_CONTROL, v);
      check("control", v & 16'hffef,
            {2'h0, 2'(p), 1'b0, 3'(tsrc[i]), 8'h00});
    end
    boot(3'h0, 2'h0);
    rd(clock_config_pkg::ADDR_CLOCK_DIVISOR, v);
    check("divisor_rst", v, 16'h3040);
    rd(clock_config_pkg::ADDR_PLL_FEEDBACK, v);
    check("feedback_rst", v, 16'h001e);
    rd(8'h07, v);
    check("unmapped", v, 16'h0000);
    t = 16'($random(seed));
    wr(clock_config_pkg::ADDR_FAST_RC_TUNE, t);
    rd(clock_config_pkg::ADDR_FAST_RC_TUNE, v);
    check("tune", 16'(tune), {10'h0, t[5:0]});
    check("tune_rd", v, {10'h0, t[5:0]});
    wr(clock_config_pkg::ADDR_OSC_CONTROL, 16'h0006);
    meas(10);
    check("aux_mode", 16'(amode), 16'h0003);
    near("aux_rate", ac, W / 12);
    near("wdt_rate", wc, W / 200);
    check("cpu_1to1", 16'(cc), 16'(ic));
    wr(clock_config_pkg::ADDR_CLOCK_DIVISOR, 16'ha840);
    meas(200);
    near("cpu_doze", cc, W / 320);
    @(posedge core_clk_in);
    irq <= 1'b1;
    @(posedge core_clk_in);
    irq <= 1'b0;
    rd(clock_config_pkg::ADDR_CLOCK_DIVISOR, v);
    check("doze_wake", v, 16'ha040);
    boot(3'h7, 2'h3);
    for (int n = 0; n < 4; n++)
    begin
      wr(clock_config_pkg::ADDR_CLOCK_DIVISOR, 16'(n << 8) | 16'h0040);
      meas(1500);
      near("frc_post", ic, W / (160 << n));
    end
    boot(3'h3, 2'h1);
    for (int i = 0; i < 6; i++)
    begin
      pre = (i < 4) ? ppre[i] : {$random(seed)} % 4;
      m = (i < 4) ? pmul[i] : {$random(seed)} % 60;
      post = (i < 4) ? ppost[i] : {$random(seed)} % 4;
      wr(clock_config_pkg::ADDR_PLL_FEEDBACK, 16'(m));
      wr(clock_config_pkg::ADDR_CLOCK_DIVISOR, 16'(post << 6 | pre));
      // Boundary wait plus three prescaled periods to relock
      meas(200 * (pre + 2) + 1500);
      near("pll_rate", ic, pll_exp(pre, m, post));
      check("pll_lock", 16'(lock), 16'h0001);
    end
    boot(3'h2, 2'h1);
    wr(clock_config_pkg::ADDR_OSC_CONTROL, 16'h0001);
    pstop <= 1'b1;
    repeat (600) @(posedge core_clk_in);
    check("fail_flag", 16'(fail), 16'h0001);
    check("fail_source", 16'(cur), 16'h0000);
    wr(clock_config_pkg::ADDR_OSC_CONTROL, 16'h0009);
    repeat (2) @(posedge core_clk_in);
    check("fail_clear", 16'(fail), 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
